// ==== hdl/ssi_master.sv ====
/*
  Controller end: AXI4-Lite register slave that issues clock
  bursts, collects the returned frame and raises an interrupt.
  Assumes the data line is asynchronous to aclk.
*/
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "ssi_params.svh"

module ssi_master (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  ssi_link_if.master       link,
  output logic             irq
);

  ssi_pkg::mst_state_e st_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic        wr_fire;
  logic [31:0] wm;
  logic        repeat_r;
  logic        start_r;
  logic [7:0]  cnt_r;
  logic [15:0] div_r;
  logic [31:0] data_r;
  logic [31:0] first_r;
  logic [31:0] sh_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_mask_r;
  logic        ev_done_r;
  logic        ev_mism_r;
  logic [15:0] tick_r;
  logic [15:0] gap_r;
  logic [7:0]  bits_r;
  logic        pass_r;
  logic        clk_r;
  logic        d_s1_r;
  logic        d_s2_r;

  // Byte lanes to bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // True for a mapped word address
  function automatic logic mapped(input logic [7:0] a);
    return a <= `SSI_REG_IRQ_MASK && a[1:0] == 2'b00;
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  // Address and data taken in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        aw_hold_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_hold_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_r) ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign wm      = wdata_r & lane_mask(wstrb_r);

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      unique case (s_axi_araddr)
        `SSI_REG_CTRL:     s_axi_rdata <= {16'h0000, cnt_r, 6'h00, repeat_r, 1'b0};
        `SSI_REG_DIV:      s_axi_rdata <= {16'h0000, div_r};
        `SSI_REG_STATUS:   s_axi_rdata <= {30'h0, d_s2_r, st_r != ssi_pkg::M_IDLE};
        `SSI_REG_DATA:     s_axi_rdata <= data_r;
        `SSI_REG_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_r};
        `SSI_REG_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_r};
        default:           s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers and interrupt
  // ----------------------------------------------------------------
  // Divider floored so the clock never beats the cable limit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      repeat_r   <= 1'b0;
      start_r    <= 1'b0;
      cnt_r      <= `SSI_CNT_RST;
      div_r      <= `SSI_DIV_RST;
      irq_mask_r <= 2'b00;
    end else begin
      start_r <= wr_fire && awaddr_r == `SSI_REG_CTRL && wm[`SSI_CTRL_START];
      if (wr_fire && awaddr_r == `SSI_REG_CTRL) begin
        if (wstrb_r[0]) repeat_r <= wdata_r[`SSI_CTRL_REPEAT];
        if (wstrb_r[1]) cnt_r <= (wdata_r[15:8] == 8'h00) ? 8'h01 : wdata_r[15:8];
      end
      if (wr_fire && awaddr_r == `SSI_REG_DIV && wstrb_r[1:0] == 2'b11) begin
        div_r <= (wdata_r[15:0] < 16'(`SSI_MIN_HALF_CYC)) ?
                 16'(`SSI_MIN_HALF_CYC) : wdata_r[15:0];
      end
      if (wr_fire && awaddr_r == `SSI_REG_IRQ_MASK && wstrb_r[0]) irq_mask_r <= wdata_r[1:0];
    end
  end

  // Write-one clears; a set in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 2'b00;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_fire && awaddr_r == `SSI_REG_IRQ_STAT) ?
                    wm[1:0] : 2'b00)) | {ev_mism_r, ev_done_r};
      irq        <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Burst generator
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      d_s1_r <= 1'b1;
      d_s2_r <= 1'b1;
    end else begin
      d_s1_r <= link.data_line;
      d_s2_r <= d_s1_r;
    end
  end

  // Samples on its own rising edge, after a full low half
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= ssi_pkg::M_IDLE;
      clk_r     <= 1'b1;
      tick_r    <= 16'h0000;
      gap_r     <= 16'hFFFF;
      bits_r    <= 8'h00;
      pass_r    <= 1'b0;
      sh_r      <= 32'h00000000;
      first_r   <= 32'h00000000;
      data_r    <= 32'h00000000;
      ev_done_r <= 1'b0;
      ev_mism_r <= 1'b0;
    end else begin
      ev_done_r <= 1'b0;
      ev_mism_r <= 1'b0;
      tick_r    <= tick_r + 16'h0001;
      if (st_r != ssi_pkg::M_LO && st_r != ssi_pkg::M_HI && gap_r != 16'hFFFF) begin
        gap_r <= gap_r + 16'h0001;
      end
      unique case (st_r)
        ssi_pkg::M_IDLE: if (start_r) begin
          pass_r <= 1'b0;
          st_r   <= ssi_pkg::M_GAP;
        end
        ssi_pkg::M_GAP: if (gap_r >= 16'(`SSI_SGL_GAP_CYC) && d_s2_r) begin
          sh_r   <= 32'h00000000;
          bits_r <= cnt_r;
          tick_r <= 16'h0000;
          clk_r  <= 1'b0;
          st_r   <= ssi_pkg::M_LO;
        end
        ssi_pkg::M_REP: if (tick_r == 16'(`SSI_REP_GAP_CYC - 1)) begin
          sh_r   <= 32'h00000000;
          bits_r <= cnt_r;
          tick_r <= 16'h0000;
          clk_r  <= 1'b0;
          st_r   <= ssi_pkg::M_LO;
        end
        ssi_pkg::M_LO: if (tick_r == div_r - 16'h0001) begin
          sh_r   <= {sh_r[30:0], d_s2_r};
          tick_r <= 16'h0000;
          clk_r  <= 1'b1;
          st_r   <= ssi_pkg::M_HI;
        end
        ssi_pkg::M_HI: if (tick_r == div_r - 16'h0001) begin
          tick_r <= 16'h0000;
          if (bits_r != 8'h01) begin
            bits_r <= bits_r - 8'h01;
            clk_r  <= 1'b0;
            st_r   <= ssi_pkg::M_LO;
          end else if (repeat_r && !pass_r) begin
            first_r <= sh_r;
            pass_r  <= 1'b1;
            st_r    <= ssi_pkg::M_REP;
          end else begin
            data_r    <= sh_r;
            ev_done_r <= 1'b1;
            ev_mism_r <= repeat_r && sh_r != first_r;
            gap_r     <= 16'h0000;
            st_r      <= ssi_pkg::M_IDLE;
          end
        end
        default: st_r <= ssi_pkg::M_IDLE;
      endcase
    end
  end

  assign link.clk_line = clk_r;

endmodule // ssi_master

// ==== hdl/ssi_params.svh ====
/*
  Constants of the serial absolute position link: timing counts,
  frame sizes, controller register offsets, fields and reset values.
  Assumes a 10 MHz system clock shared by both ends.
*/
`ifndef SSI_PARAMS_SVH
`define SSI_PARAMS_SVH

// Notes on behaviour
// - Up to 24 data bits, then alarm, parity
// - Position sent in gray or binary
// - Repeat resends stored word; 25-26 clocks
// - Repeat needs burst pause under 10 us
// - Fresh read needs pause over 30 us
// - After frame: data low 20 us, then high
// - Clock rate limited by cable length
// - Resolution, code, direction, warning, alarm configurable
// - Status lamp green normal, red on alarm
// - Single-turn 10 to 17 bits, 13 multiturn; the encoder clamps to 10..ST_BITS (13 by default) with 11 multiturn bits

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSI_CLK_MHZ        10
`define SSI_HOLD_US        20
`define SSI_HOLD_CYC       (`SSI_HOLD_US * `SSI_CLK_MHZ)
`define SSI_REP_GAP_US     5
`define SSI_REP_GAP_CYC    (`SSI_REP_GAP_US * `SSI_CLK_MHZ)
`define SSI_SGL_GAP_US     40
`define SSI_SGL_GAP_CYC    (`SSI_SGL_GAP_US * `SSI_CLK_MHZ)
`define SSI_MIN_PERIOD_NS  2500
`define SSI_MIN_HALF_CYC   ((`SSI_MIN_PERIOD_NS * `SSI_CLK_MHZ + 1999) / 2000)

// ----------------------------------------------------------------
// Frame
// ----------------------------------------------------------------
`define SSI_DATA_W         24
`define SSI_FRAME_W        26
`define SSI_ST_MIN         10

// ----------------------------------------------------------------
// Controller registers
// ----------------------------------------------------------------
`define SSI_REG_CTRL       8'h00
`define SSI_REG_DIV        8'h04
`define SSI_REG_STATUS     8'h08
`define SSI_REG_DATA       8'h0C
`define SSI_REG_IRQ_STAT   8'h10
`define SSI_REG_IRQ_MASK   8'h14
`define SSI_CTRL_START     0
`define SSI_CTRL_REPEAT    1
`define SSI_CTRL_CNT_LSB   8
`define SSI_CNT_RST        8'h1A
`define SSI_DIV_RST        16'h000D
`define SSI_IRQ_DONE       0
`define SSI_IRQ_MISM       1

`endif

// ==== hdl/ssi_pkg.sv ====
/*
  Types shared by both ends of the serial position link.
  Assumes the constants header is on the include path.
*/
`include "ssi_params.svh"

package ssi_pkg;
  typedef enum logic [1:0] {ENC_IDLE, ENC_SHIFT, ENC_HOLD} enc_state_e;
  typedef enum logic [2:0] {M_IDLE, M_GAP, M_LO, M_HI, M_REP} mst_state_e;
  typedef logic [`SSI_FRAME_W-1:0] frame_t;
endpackage

// ==== hdl/ssi_link_if.sv ====
/*
  Two wires of the serial position link: clock from controller,
  data from encoder. Both are plain one-way lines.
*/
`timescale 1ns/1ps

interface ssi_link_if;
  logic clk_line;
  logic data_line;
  modport master  (output clk_line, input data_line);
  modport encoder (input clk_line, output data_line);
endinterface

// ==== hdl/ssi_encoder.sv ====
/*
  Encoder end: latches the position at the first clock edge of a
  burst from idle and shifts it out, then holds the line low before idling.
  Assumes the link clock is asynchronous and position and
  configuration inputs are synchronous to aclk.
*/
`timescale 1ns/1ps
`include "ssi_params.svh"

module ssi_encoder #(
  parameter int ST_BITS = 13,
  parameter int MT_BITS = 11
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  ssi_link_if.encoder             link,
  input  wire logic [ST_BITS-1:0] st_pos,
  input  wire logic [MT_BITS-1:0] mt_pos,
  input  wire logic [4:0]         st_res,
  input  wire logic               code_gray,
  input  wire logic               dir_ccw,
  input  wire logic               warn_en,
  input  wire logic               alarm_en,
  input  wire logic               parity_en,
  input  wire logic               warning_in,
  input  wire logic               alarm_in,
  output logic                    led_green,
  output logic                    led_red
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ssi_pkg::enc_state_e state_r;
  ssi_pkg::frame_t     frame_r;
  ssi_pkg::frame_t     shift_r;
  ssi_pkg::frame_t     frame_nxt;
  logic [4:0]          len_r;
  logic [4:0]          len_nxt;
  logic [4:0]          left_r;
  logic [15:0]         tmr_r;
  logic                data_r;
  logic                clk_s1_r;
  logic                clk_s2_r;
  logic                clk_d_r;
  logic                fall;
  logic                rise;
  logic [4:0]          res;
  logic [ST_BITS-1:0]  st_sc;
  logic [MT_BITS-1:0]  mt_d;
  logic [23:0]         word_bin;
  logic [23:0]         word;
  logic                alarm_bit;
  logic                par_bit;

  // Reflected gray of a binary word
  function automatic logic [23:0] to_gray(input logic [23:0] b);
    return b ^ (b >> 1);
  endfunction

  // ----------------------------------------------------------------
  // Link clock sampling
  // ----------------------------------------------------------------
  // Two stages before use; the first is read by the second only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_s1_r <= 1'b1;
      clk_s2_r <= 1'b1;
      clk_d_r  <= 1'b1;
    end else begin
      clk_s1_r <= link.clk_line;
      clk_s2_r <= clk_s1_r;
      clk_d_r  <= clk_s2_r;
    end
  end

  // Edges seen in the system domain
  assign fall = clk_d_r & ~clk_s2_r;
  assign rise = ~clk_d_r & clk_s2_r;

  // ----------------------------------------------------------------
  // Position word build
  // ----------------------------------------------------------------
  // Resolution clamped to the legal single-turn span
  always_comb begin
    if (st_res < 5'(`SSI_ST_MIN)) begin
      res = 5'(`SSI_ST_MIN);
    end else if (st_res > 5'(ST_BITS)) begin
      res = 5'(ST_BITS);
    end else begin
      res = st_res;
    end
  end

  // Complement before scaling reverses the count within the range
  always_comb begin
    st_sc = (dir_ccw ? ~st_pos : st_pos) >> (5'(ST_BITS) - res);
    mt_d  = dir_ccw ? ~mt_pos : mt_pos;
    word_bin = (24'(mt_d) << res) | 24'(st_sc);
    word = code_gray ? to_gray(word_bin) : word_bin;
    alarm_bit = alarm_in | (warn_en & warning_in);
    par_bit = ^{word, alarm_en & alarm_bit};
  end

  // Special bits packed straight after the data bits
  always_comb begin
    unique case ({alarm_en, parity_en})
      2'b11: frame_nxt = {word, alarm_bit, par_bit};
      2'b10: frame_nxt = {word, alarm_bit, 1'b0};
      2'b01: frame_nxt = {word, par_bit, 1'b0};
      2'b00: frame_nxt = {word, 2'b00};
    endcase
    len_nxt = 5'(`SSI_DATA_W) + 5'(alarm_en) + 5'(parity_en);
  end

  // ----------------------------------------------------------------
  // Shift and hold sequence
  // ----------------------------------------------------------------
  // Bits change on falling edges so the controller samples on rising
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ssi_pkg::ENC_IDLE;
      frame_r <= '0;
      shift_r <= '0;
      len_r   <= 5'h00;
      left_r  <= 5'h00;
      tmr_r   <= 16'h0000;
      data_r  <= 1'b1;
    end else begin
      unique case (state_r)
        ssi_pkg::ENC_IDLE: begin
          data_r <= 1'b1;
          if (fall) begin
            frame_r <= frame_nxt;
            len_r   <= len_nxt;
            data_r  <= frame_nxt[`SSI_FRAME_W-1];
            shift_r <= frame_nxt << 1;
            left_r  <= len_nxt - 5'h01;
            state_r <= ssi_pkg::ENC_SHIFT;
          end
        end
        ssi_pkg::ENC_SHIFT: begin
          if (fall && left_r != 5'h00) begin
            data_r  <= shift_r[`SSI_FRAME_W-1];
            shift_r <= shift_r << 1;
            left_r  <= left_r - 5'h01;
          end else if (rise && left_r == 5'h00) begin
            data_r  <= 1'b0;
            tmr_r   <= 16'h0000;
            state_r <= ssi_pkg::ENC_HOLD;
          end
        end
        ssi_pkg::ENC_HOLD: begin
          tmr_r <= tmr_r + 16'h0001;
          if (fall) begin
            // Burst inside the hold: send the same stored word again
            data_r  <= frame_r[`SSI_FRAME_W-1];
            shift_r <= frame_r << 1;
            left_r  <= len_r - 5'h01;
            state_r <= ssi_pkg::ENC_SHIFT;
          end else if (tmr_r == 16'(`SSI_HOLD_CYC - 1)) begin
            data_r  <= 1'b1;
            state_r <= ssi_pkg::ENC_IDLE;
          end
        end
      endcase
    end
  end

  assign link.data_line = data_r;

  // ----------------------------------------------------------------
  // Status lamp
  // ----------------------------------------------------------------
  // Lamp follows the live alarm, not the latched frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_green <= 1'b1;
      led_red   <= 1'b0;
    end else begin
      led_green <= ~alarm_in;
      led_red   <= alarm_in;
    end
  end

endmodule // ssi_encoder

// ==== verification/ssi_link_sva.sv ====
/*
  Timing checker for the two wires of the serial position link.
  Assumes both wires are sampled on the shared 10 MHz system clock.
*/
`timescale 1ns/1ps

module ssi_link_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_line,
  input wire logic data_line
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  int lo_run;
  int hi_run;

  // Data low while the link clock rests high
  always_ff @(posedge aclk) begin
    if (!aresetn || !clk_line || data_line) lo_run <= 0;
    else lo_run <= lo_run + 1;
  end

  // Clock high run; reset counts as a long idle so no false gap
  always_ff @(posedge aclk) begin
    if (!aresetn) hi_run <= 1000;
    else if (!clk_line) hi_run <= 0;
    else if (hi_run < 1000) hi_run <= hi_run + 1;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_DATA_RST_HIGH: assert property (disable iff (1'b0) !aresetn |=> data_line)
    else $error("data line not high after reset");
  AST_CLK_RST_HIGH: assert property (disable iff (1'b0) !aresetn |=> clk_line)
    else $error("link clock not high after reset");
  AST_LOW_HALF: assert property ($fell(clk_line) |-> !clk_line[*8] ##1 !clk_line[*5])
    else $error("link clock low half too short");
  AST_HIGH_HALF: assert property ($rose(clk_line) |-> clk_line[*8] ##1 clk_line[*5])
    else $error("link clock high half too short");
  AST_HOLD_MAX: assert property (lo_run <= 230)
    else $error("data held low too long after frame");
  AST_HOLD_LEN: assert property (($rose(data_line) && clk_line) |-> lo_run inside {[180:230]})
    else $error("low hold after frame has wrong length");
  AST_BURST_GAP: assert property ($fell(clk_line) |-> (hi_run < 100 || hi_run > 300))
    else $error("pause between bursts in forbidden band");
  AST_BIT_STABLE: assert property ($rose(clk_line) |-> ##6 $stable(data_line)[*6])
    else $error("data bit changed while link clock high");

  // Main scenarios seen
  COV_BURST: cover property ($fell(clk_line));
  COV_HOLD_END: cover property ($rose(data_line) && clk_line);
  COV_REPEAT: cover property ($fell(clk_line) && hi_run > 20 && hi_run < 100);
endmodule // ssi_link_sva

// ==== verification/test_ssi_absolute_position_output.sv ====
/*
  Self-checking bench: controller and encoder joined by the link,
  software side driven over AXI4-Lite, encoder inputs by the bench.
  Assumes the constants header is on the include path.
*/
`timescale 1ns/1ps
`include "ssi_params.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

module test_ssi_absolute_position_output;
  logic        aclk, aresetn, irq, led_green, led_red;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [12:0] st_pos;
  logic [10:0] mt_pos;
  logic [4:0]  st_res;
  logic        code_gray, dir_ccw, warn_en, alarm_en, parity_en, warning_in, alarm_in;
  int          fail_count, tests_run;

  // ----------------------------------------------------------------
  // Design, link and checker
  // ----------------------------------------------------------------
  ssi_link_if link ();
  ssi_master u_ssi_master (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link), .irq(irq));
  ssi_encoder u_ssi_encoder (.aclk(aclk), .aresetn(aresetn), .link(link), .st_pos(st_pos),
    .mt_pos(mt_pos), .st_res(st_res), .code_gray(code_gray), .dir_ccw(dir_ccw),
    .warn_en(warn_en), .alarm_en(alarm_en), .parity_en(parity_en), .warning_in(warning_in),
    .alarm_in(alarm_in), .led_green(led_green), .led_red(led_red));
  ssi_link_sva u_ssi_link_sva (.aclk(aclk), .aresetn(aresetn), .clk_line(link.clk_line),
    .data_line(link.data_line));

  always #50 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        w_ok = 1;
        wvalid <= 1'h0;
      end
    end
    while (bvalid !== 1'h1) @(posedge aclk);
    bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    `CHK(n, e, d)
  endtask

  // Frame as collected: data word, then alarm and parity if enabled
  function automatic logic [31:0] exp_frame(input logic [12:0] st, input logic [10:0] mt,
    input int res, input bit gray, input bit ccw, input bit al, input bit ae, input bit pe);
    logic [23:0] v;
    logic [31:0] f;
    if (ccw) begin
      st = ~st;
      mt = ~mt;
    end
    v = (24'(mt) << res) | 24'(st >> (13 - res));
    if (gray) v = v ^ (v >> 1);
    f = 32'(v);
    if (ae) f = {f[30:0], al};
    if (pe) f = {f[30:0], ^{v, al & ae}};
    return f;
  endfunction

  // Start a burst, wait for the done interrupt, compare the frame
  task automatic do_read(input logic [31:0] ctrl, input logic [31:0] e, input logic [31:0] s);
    int n;
    axi_wr(`SSI_REG_CTRL, ctrl);
    n = 0;
    while (irq !== 1'h1 && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    // A read that never finishes counts here, not only in the frame
    `CHK("done irq", 1'h1, irq)
    chk_rd(`SSI_REG_DATA, e, "frame");
    chk_rd(`SSI_REG_IRQ_STAT, s, "irq status");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    `CHK("data idle", 1'h1, link.data_line)
    chk_rd(`SSI_REG_CTRL, {16'h0, `SSI_CNT_RST, 8'h00}, "ctrl");
    chk_rd(`SSI_REG_DIV, {16'h0, `SSI_DIV_RST}, "div");
    // Too fast a divider must be raised to the cable floor
    axi_wr(`SSI_REG_DIV, 32'h1);
    chk_rd(`SSI_REG_DIV, 32'(`SSI_MIN_HALF_CYC), "div floor");
    chk_rd(`SSI_REG_STATUS, 32'h2, "status");
    axi_rd(8'h18, d, r);
    `CHK("unmapped", 2'h2, r)
    axi_wr(`SSI_REG_IRQ_MASK, 32'h3);
  endtask

  // Binary, warning ignored without warn_en; interrupt masked and cleared
  task automatic t_binary();
    do_read(32'h1A01, exp_frame(13'h1A5B, 11'h4C3, 13, 0, 0, 0, 1, 1), 32'h1);
    axi_wr(`SSI_REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    `CHK("irq masked", 1'h0, irq)
    axi_wr(`SSI_REG_IRQ_MASK, 32'h3);
    repeat (2) @(posedge aclk);
    `CHK("irq unmasked", 1'h1, irq)
    axi_wr(`SSI_REG_IRQ_STAT, 32'h3);
    repeat (2) @(posedge aclk);
    `CHK("irq cleared", 1'h0, irq)
  endtask

  // Gray, reversed, lowest resolution, warning routed to alarm bit
  task automatic t_gray();
    st_res <= 5'h0A;
    code_gray <= 1'h1;
    dir_ccw <= 1'h1;
    warn_en <= 1'h1;
    do_read(32'h1A01, exp_frame(13'h1A5B, 11'h4C3, 10, 1, 1, 1, 1, 1), 32'h1);
    axi_wr(`SSI_REG_IRQ_STAT, 32'h3);
  endtask

  // Repeat mode: second burst resends the stored word, no mismatch
  task automatic t_repeat();
    st_res <= 5'h0D;
    code_gray <= 1'h0;
    dir_ccw <= 1'h0;
    warn_en <= 1'h0;
    // Position moves after the latch; the second burst must not see it
    fork
      do_read(32'h1A03, exp_frame(13'h1A5B, 11'h4C3, 13, 0, 0, 0, 1, 1), 32'h1);
      begin
        wait (link.clk_line === 1'h0);
        repeat (100) @(posedge aclk);
        st_pos <= 13'h0123;
      end
    join
    st_pos <= 13'h1A5B;
    axi_wr(`SSI_REG_IRQ_STAT, 32'h3);
  endtask

  // Bare 24 bit word, then the line returns high after the hold
  task automatic t_short();
    alarm_en <= 1'h0;
    parity_en <= 1'h0;
    do_read(32'h1801, exp_frame(13'h1A5B, 11'h4C3, 13, 0, 0, 0, 0, 0), 32'h1);
    repeat (300) @(posedge aclk);
    `CHK("idle after hold", 1'h1, link.data_line)
  endtask

  task automatic t_lamp();
    alarm_in <= 1'h1;
    repeat (3) @(posedge aclk);
    `CHK("red on alarm", 1'h1, led_red)
    `CHK("green off on alarm", 1'h0, led_green)
    alarm_in <= 1'h0;
    repeat (3) @(posedge aclk);
    `CHK("green when ok", 1'h1, led_green)
  endtask

  task automatic report_and_stop();
    $display("errors %0d checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog sized well above four reads with their gaps
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wdata} = 48'h0;
    {fail_count, tests_run} = 0;
    st_pos = 13'h1A5B;
    mt_pos = 11'h4C3;
    st_res = 5'h0D;
    {code_gray, dir_ccw, warn_en, alarm_in} = 4'h0;
    {alarm_en, parity_en, warning_in} = 3'h7;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_binary();
    t_gray();
    t_repeat();
    t_short();
    t_lamp();
    report_and_stop();
  end
endmodule // test_ssi_absolute_position_output
